// ---- core/rcl_ctrl.sv ----
/*
  rcl_ctrl: reset-time strap capture and run/wait/doze/stop sequencing.
  assumes straps are held by the board during reset, a wishbone master on clk_i,
  and that the clock controller gates clocks from the enables driven here.
*/
// Local design decisions: the register offsets and the Wishbone register port.
// How it works
// - active low enable selects sampled straps
// - boot width 00/11=32, 10=8, 01=16
// - drive strap 1 full, 0 partial
// - clock mode pins decode four sources
// - two straps share upper address with selects
// - system clock held low in stop
// - only wakeup events return to run
// - wait stops only the core clock
// - doze gates core, mode code visible
// - doze leaves peripheral clocks running, as wait does
// - stop halts all clocks and peripherals
// - peripherals keep state across stop
// - disabled peripheral stays disabled always
// - software can shut bus clock output
`timescale 1ns/100ps
module rcl_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // strap pins
  input wire logic config_enable_n_i,
  input wire logic [1:0] boot_width_straps_i,
  input wire logic drive_strength_strap_i,
  input wire logic [1:0] cs_addr_select_straps_i,
  input wire logic clock_src_sel_hi_i,
  input wire logic clock_src_sel_lo_i,
  // core side
  input wire logic stop_insn_i,
  input wire logic breakpoint_request_n_i,
  input wire logic irq_pending_i,
  // configuration results
  output logic [1:0] boot_width_o,
  output logic full_drive_o,
  output logic [1:0] clock_mode_o,
  output logic [1:0] cs_addr_sel_o,
  // clock gating
  output logic [1:0] low_power_mode_field_o,
  output logic core_clk_en_o,
  output logic sys_clk_en_o,
  output logic [7:0] peri_clk_en_o,
  output logic bus_clock_out_en_o,
  output logic debug_req_o
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [7:0] pins_s;
  logic breakpoint_request_n_n_s;

  rcl_sync #(.W(8), .RST_VAL(8'h00)) u_sync_straps (
    .clk_i(clk_i),
    .rst_i(1'b0),
    .d_i({config_enable_n_i, cs_addr_select_straps_i, clock_src_sel_hi_i,
          clock_src_sel_lo_i, drive_strength_strap_i, boot_width_straps_i}),
    .q_o(pins_s)
  );

  rcl_sync #(.W(1), .RST_VAL(1'b1)) u_sync_breakpoint_request_n (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(breakpoint_request_n_i),
    .q_o(breakpoint_request_n_n_s)
  );

  // ----------------------------------------
  // strap decode
  // ----------------------------------------
  function automatic logic [1:0] dec_width(input logic [1:0] p);
    unique case (p)
      2'h2: dec_width = rcl_pkg::BW_8;
      2'h1: dec_width = rcl_pkg::BW_16;
      default: dec_width = rcl_pkg::BW_32;
    endcase
  endfunction : dec_width

  logic cfg_en_s;
  assign cfg_en_s = ~pins_s[7];

  // ----------------------------------------
  // strap capture
  // ----------------------------------------
  logic [1:0] boot_width_ff;
  logic full_drive_ff;
  logic [1:0] clock_mode_ff;
  logic [1:0] cs_addr_sel_ff;
  logic cfg_used_ff;

  // track during reset, freeze at release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      if (cfg_en_s) begin
        boot_width_ff <= dec_width(pins_s[1:0]);
        full_drive_ff <= pins_s[2];
        clock_mode_ff <= {pins_s[4], pins_s[3]};
        cs_addr_sel_ff <= pins_s[6:5];
        cfg_used_ff <= 1'b1;
      end else begin
        boot_width_ff <= rcl_pkg::BW_DEF;
        full_drive_ff <= rcl_pkg::DRV_DEF;
        clock_mode_ff <= rcl_pkg::CLK_DEF;
        cs_addr_sel_ff <= rcl_pkg::CS_DEF;
        cfg_used_ff <= 1'b0;
      end
    end
  end

  assign boot_width_o = boot_width_ff;
  assign full_drive_o = full_drive_ff;
  assign clock_mode_o = clock_mode_ff;
  assign cs_addr_sel_o = cs_addr_sel_ff;

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  logic [1:0] low_power_mode_field_ff;
  logic dbgreq_ff;
  logic busclk_off_ff;
  logic [7:0] peri_en_ff;
  logic ack_ff;
  logic [31:0] dat_ff;
  logic wr_req;
  logic rd_req;
  rcl_pkg::rcl_state_t state_ff;
  rcl_pkg::rcl_state_t nxt_state;

  assign wr_req = cyc_i & stb_i & we_i & ~ack_ff;
  assign rd_req = cyc_i & stb_i & ~we_i & ~ack_ff;

  // a low-byte write strobe aimed at one register
  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = wr_req && (adr_i == ofs) && sel_i[0];
  endfunction : wr_hit

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= cyc_i & stb_i & ~ack_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_power_mode_field_ff <= rcl_pkg::LPC_LOW_POWER_MODE_FIELD_RST;
      busclk_off_ff <= 1'b0;
    end else if (wr_hit(rcl_pkg::LPC_OFS)) begin
      low_power_mode_field_ff <= dat_i[rcl_pkg::LOW_POWER_MODE_FIELD_LSB +: 2];
      busclk_off_ff <= dat_i[rcl_pkg::BUSCLK_OFF_BIT];
    end
  end

  // debug request bit self-clears once it has woken the core
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dbgreq_ff <= 1'b0;
    end else if (wr_hit(rcl_pkg::LPC_OFS)) begin
      dbgreq_ff <= dat_i[rcl_pkg::DBGREQ_BIT];
    end else if (dbgreq_ff && state_ff == rcl_pkg::ST_RUN) begin
      dbgreq_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      peri_en_ff <= rcl_pkg::PERI_EN_RST;
    end else if (wr_hit(rcl_pkg::PERI_OFS)) begin
      peri_en_ff <= dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_ff <= 32'h0000_0000;
    end else if (rd_req) begin
      unique case (adr_i)
        rcl_pkg::LPC_OFS: dat_ff <= {26'h0, busclk_off_ff, dbgreq_ff, 2'h0, low_power_mode_field_ff};
        rcl_pkg::CFG_OFS: dat_ff <= {24'h0, cfg_used_ff, cs_addr_sel_ff, clock_mode_ff,
                                     full_drive_ff, boot_width_ff};
        rcl_pkg::PERI_OFS: dat_ff <= {24'h0, peri_en_ff};
        rcl_pkg::STAT_OFS: dat_ff <= {28'h0, state_ff};
        default: dat_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign ack_o = ack_ff;
  assign dat_o = dat_ff;

  // ----------------------------------------
  // low power sequencer
  // ----------------------------------------
  logic wake;
  assign wake = ~breakpoint_request_n_n_s | dbgreq_ff | irq_pending_i;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      rcl_pkg::ST_RUN: begin
        if (stop_insn_i && !wake) begin
          unique case (low_power_mode_field_ff)
            rcl_pkg::LOW_POWER_MODE_FIELD_WAIT: nxt_state = rcl_pkg::ST_WAIT;
            rcl_pkg::LOW_POWER_MODE_FIELD_DOZE: nxt_state = rcl_pkg::ST_DOZE;
            rcl_pkg::LOW_POWER_MODE_FIELD_STOP: nxt_state = rcl_pkg::ST_STOP;
            default: nxt_state = rcl_pkg::ST_RUN;
          endcase
        end
      end
      rcl_pkg::ST_WAIT, rcl_pkg::ST_DOZE, rcl_pkg::ST_STOP: begin
        if (wake) begin
          nxt_state = rcl_pkg::ST_RUN;
        end
      end
      default: nxt_state = rcl_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= rcl_pkg::ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------
  // clock enables
  // ----------------------------------------
  logic core_en_ff;
  logic sys_en_ff;
  logic [7:0] peri_ff;
  logic busclk_ff;

  // wait and doze gate core only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_en_ff <= 1'b1;
    end else begin
      core_en_ff <= (nxt_state == rcl_pkg::ST_RUN);
    end
  end

  // system clock stopped low in stop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_en_ff <= 1'b1;
    end else begin
      sys_en_ff <= (nxt_state != rcl_pkg::ST_STOP);
    end
  end

  // disabled stays off in every mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      peri_ff <= rcl_pkg::PERI_EN_RST;
    end else begin
      peri_ff <= (nxt_state == rcl_pkg::ST_STOP) ? 8'h00 : peri_en_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busclk_ff <= 1'b1;
    end else begin
      busclk_ff <= ~busclk_off_ff & (nxt_state != rcl_pkg::ST_STOP);
    end
  end

  assign core_clk_en_o = core_en_ff;
  assign sys_clk_en_o = sys_en_ff;
  assign peri_clk_en_o = peri_ff;
  assign bus_clock_out_en_o = busclk_ff;
  assign low_power_mode_field_o = low_power_mode_field_ff;
  assign debug_req_o = dbgreq_ff | ~breakpoint_request_n_n_s;

endmodule : rcl_ctrl

// ---- pkg/rcl_pkg.sv ----
/*
  rcl_pkg: constants for the reset configuration and low-power control block.
  assumes a 32-bit classic wishbone register bus and one 20 MHz clock.
*/
package rcl_pkg;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] LPC_OFS = 8'h00;
  localparam logic [7:0] CFG_OFS = 8'h04;
  localparam logic [7:0] PERI_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0c;

  // ----------------------------------------
  // low power control register fields
  // ----------------------------------------
  localparam int LOW_POWER_MODE_FIELD_LSB = 0;
  localparam int DBGREQ_BIT = 4;
  localparam int BUSCLK_OFF_BIT = 5;
  localparam logic [1:0] LPC_LOW_POWER_MODE_FIELD_RST = 2'h0;

  // low power mode codes
  localparam logic [1:0] LOW_POWER_MODE_FIELD_RUN = 2'h0;
  localparam logic [1:0] LOW_POWER_MODE_FIELD_DOZE = 2'h1;
  localparam logic [1:0] LOW_POWER_MODE_FIELD_WAIT = 2'h2;
  localparam logic [1:0] LOW_POWER_MODE_FIELD_STOP = 2'h3;

  // ----------------------------------------
  // configuration field positions and defaults
  // ----------------------------------------
  localparam int CFG_BW_LSB = 0;
  localparam int CFG_DRV_BIT = 2;
  localparam int CFG_CLK_LSB = 3;
  localparam int CFG_CS_LSB = 5;
  localparam int CFG_EN_BIT = 7;

  localparam logic [1:0] BW_32 = 2'h0;
  localparam logic [1:0] BW_8 = 2'h2;
  localparam logic [1:0] BW_16 = 2'h1;
  localparam logic [1:0] BW_DEF = BW_32;
  localparam logic DRV_DEF = 1'b0;
  localparam logic [1:0] CLK_NOPLL = 2'h0;
  localparam logic [1:0] CLK_PLL11 = 2'h1;
  localparam logic [1:0] CLK_PLLEXT = 2'h2;
  localparam logic [1:0] CLK_PLLXTAL = 2'h3;
  localparam logic [1:0] CLK_DEF = CLK_PLLXTAL;
  localparam logic [1:0] CS_ADDR_ALL = 2'h0;
  localparam logic [1:0] CS_DEF = CS_ADDR_ALL;

  localparam int NUM_PERI = 8;
  localparam logic [7:0] PERI_EN_RST = 8'hff;

  // ----------------------------------------
  // state machine
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_WAIT = 4'h2,
    ST_DOZE = 4'h4,
    ST_STOP = 4'h8
  } rcl_state_t;

endpackage : rcl_pkg

// ---- core/rcl_sync.sv ----
/*
  rcl_sync: two flip-flop synchroniser for a bundle of pin levels.
  assumes inputs are asynchronous to clk_i.
*/
`timescale 1ns/100ps
module rcl_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;

endmodule : rcl_sync

// ---- bench/rcl_monitor.sv ----
/* rcl_monitor: port assertions for rcl_ctrl.
   assumes one clock and a synchronous active high reset. */
`timescale 1ns/100ps
module rcl_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic stop_insn_i,
  input wire logic breakpoint_request_n_i,
  input wire logic irq_pending_i,
  input wire logic [1:0] boot_width_o,
  input wire logic full_drive_o,
  input wire logic [1:0] clock_mode_o,
  input wire logic [1:0] cs_addr_sel_o,
  input wire logic [1:0] low_power_mode_field_o,
  input wire logic core_clk_en_o,
  input wire logic sys_clk_en_o,
  input wire logic [7:0] peri_clk_en_o,
  input wire logic bus_clock_out_en_o,
  input wire logic debug_req_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic wake;
  assign wake = irq_pending_i || !breakpoint_request_n_i || debug_req_o;
  AST_ACK_ONE: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acked");
  AST_ACK_DROP: assert property (ack_o |=> !ack_o)
    else $error("ack held");
  AST_ENTRY: assert property (
    core_clk_en_o && stop_insn_i && low_power_mode_field_o != 2'h0 && !wake |=> !core_clk_en_o)
    else $error("stop not taken");
  AST_REFUSE: assert property (
    core_clk_en_o && stop_insn_i && low_power_mode_field_o == 2'h0 |=> core_clk_en_o)
    else $error("stop taken with run code");
  AST_STOP_LOW: assert property (
    !sys_clk_en_o |-> !core_clk_en_o && peri_clk_en_o == 8'h00 && !bus_clock_out_en_o
    && low_power_mode_field_o == 2'h3) else $error("stop clocks wrong");
  AST_WAIT_CORE: assert property (
    !core_clk_en_o && low_power_mode_field_o != 2'h3 |-> sys_clk_en_o)
    else $error("system clock off outside stop");
  AST_WAKE: assert property (!core_clk_en_o && irq_pending_i |=> core_clk_en_o)
    else $error("no wake on interrupt");
  AST_NO_WAKE: assert property (!core_clk_en_o && !wake |=> !core_clk_en_o)
    else $error("spurious wake");
  AST_CFG_HOLD: assert property (
    !$past(rst_i) |-> $stable({boot_width_o, full_drive_o, clock_mode_o, cs_addr_sel_o}))
    else $error("config changed after reset");
  AST_BREAKPOINT_REQUEST_N: assert property (!breakpoint_request_n_i [*3] |-> debug_req_o)
    else $error("breakpoint not seen");
  cover property (!sys_clk_en_o);
  cover property (!core_clk_en_o && sys_clk_en_o);
  cover property (ack_o);
endmodule : rcl_monitor

bind rcl_ctrl rcl_monitor mon_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .stop_insn_i(stop_insn_i), .breakpoint_request_n_i(breakpoint_request_n_i), .irq_pending_i(irq_pending_i),
  .boot_width_o(boot_width_o), .full_drive_o(full_drive_o), .clock_mode_o(clock_mode_o),
  .cs_addr_sel_o(cs_addr_sel_o), .low_power_mode_field_o(low_power_mode_field_o),
  .core_clk_en_o(core_clk_en_o), .sys_clk_en_o(sys_clk_en_o), .peri_clk_en_o(peri_clk_en_o),
  .bus_clock_out_en_o(bus_clock_out_en_o), .debug_req_o(debug_req_o));

// ---- bench/rcl_board.sv ----
/* rcl_board: board straps for the configuration pins.
   assumes reset is held several clocks; pins wiggle after it. */
`timescale 1ns/100ps
module rcl_board (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] strap_i,
  output logic [7:0] pins_o
);
  logic [7:0] pin_ff = 8'h00;
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_ff <= strap_i;
    end else begin
      pin_ff <= ~pin_ff;
    end
  end
  assign pins_o = pin_ff;
endmodule : rcl_board

// ---- bench/testbench.sv ----
/* testbench: straps, bus and low power checks of rcl_ctrl.
   assumes the board model and the bound monitor. */
`timescale 1ns/100ps
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, stop_i = 1'b0, bk_n = 1'b1, irq = 1'b0;
  logic [7:0] adr_i = 8'h00, strap = 8'h00, pins, s, e, pe;
  logic [31:0] dat_i = 32'h0, dat_o, rd, seed = 32'h0001_6f23;
  logic ack_o, fd, cce, sce, bce, dbg;
  logic [1:0] bw, cm, cs, lpm;
  logic [7:0] peri;
  int mismatches = 0, samples_checked = 0, cycles = 0;
  always #25 clk_i = ~clk_i;
  rcl_board board_u (.clk_i(clk_i), .rst_i(rst_i), .strap_i(strap), .pins_o(pins));
  rcl_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .config_enable_n_i(pins[0]),
    .boot_width_straps_i(pins[2:1]), .drive_strength_strap_i(pins[3]), .cs_addr_select_straps_i(pins[5:4]),
    .clock_src_sel_hi_i(pins[6]), .clock_src_sel_lo_i(pins[7]), .stop_insn_i(stop_i),
    .breakpoint_request_n_i(bk_n), .irq_pending_i(irq), .boot_width_o(bw), .full_drive_o(fd),
    .clock_mode_o(cm), .cs_addr_sel_o(cs), .low_power_mode_field_o(lpm), .core_clk_en_o(cce),
    .sys_clk_en_o(sce), .peri_clk_en_o(peri), .bus_clock_out_en_o(bce), .debug_req_o(dbg));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 16);
    chk(ack_o, 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    // registered outputs settle one edge after the ack
    @(posedge clk_i);
  endtask : wb
  // ------
  // low power entry and wake
  // ------
  task automatic lp(input logic [1:0] m, input logic [1:0] src);
    int n;
    pe = 8'(xs());
    wb(rcl_pkg::PERI_OFS, 1'b1, {24'h0, pe});
    wb(rcl_pkg::LPC_OFS, 1'b1, {30'h0, m});
    @(posedge clk_i);
    stop_i <= 1'b1;
    @(posedge clk_i);
    stop_i <= 1'b0;
    @(posedge clk_i);
    chk({sce, cce, peri, lpm}, {m != 2'h3, m == 2'h0, (m == 2'h3) ? 8'h00 : pe, m});
    wb(rcl_pkg::STAT_OFS, 1'b0, 32'h0);
    chk(rd, (m == 2'h0) ? 32'h1 : (m == 2'h1) ? 32'h4 : (m == 2'h2) ? 32'h2 : 32'h8);
    repeat (2 + xs() % 8) @(posedge clk_i);
    chk(cce, m == 2'h0);
    // wake source: 0 interrupt, 1 breakpoint pin, 2 debug request bit
    irq <= (src == 2'h0);
    bk_n <= (src != 2'h1);
    if (src == 2'h2) begin
      wb(rcl_pkg::LPC_OFS, 1'b1, {26'h0, 2'h1, 2'h0, m});
    end
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (cce !== 1'b1 && n < 8);
    chk({cce, sce, peri, dbg}, {2'h3, pe, src == 2'h1});
    @(posedge clk_i);
    irq <= 1'b0;
    bk_n <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask : lp
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    for (int i = 0; i < 8; i++) begin
      s = 8'(xs());
      s[2:1] = 2'(i);
      s[5:4] = 2'(i);
      s[7:6] = 2'(i >> 1);
      s[0] = (i > 5);
      e = s[0] ? {1'b0, rcl_pkg::CS_DEF, rcl_pkg::CLK_DEF, rcl_pkg::DRV_DEF, rcl_pkg::BW_DEF}
        : {1'b1, s[5:4], s[6], s[7], s[3], (s[2:1] == 2'h3) ? 2'h0 : s[2:1]};
      @(posedge clk_i);
      rst_i <= 1'b1;
      strap <= s;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(rcl_pkg::CFG_OFS, 1'b1, 32'hff);
      chk({cs, cm, fd, bw}, e[6:0]);
      wb(rcl_pkg::CFG_OFS, 1'b0, 32'h0);
      chk(rd, {24'h0, e});
      wb(rcl_pkg::PERI_OFS, 1'b0, 32'h0);
      chk(rd, {24'h0, rcl_pkg::PERI_EN_RST});
    end
    wb(8'h10, 1'b0, 32'h0);
    chk(rd, 32'h0);
    wb(rcl_pkg::LPC_OFS, 1'b1, 32'h20);
    chk(bce, 1'b0);
    wb(rcl_pkg::LPC_OFS, 1'b1, 32'h0);
    chk(bce, 1'b1);
    for (int m = 0; m < 4; m++) begin
      lp(2'(m), 2'h0);
    end
    lp(2'h3, 2'h1);
    lp(2'h1, 2'h1);
    lp(2'h3, 2'h2);
    lp(2'h2, 2'h2);
    give_verdict();
  end
endmodule : testbench
